/* File: dbc_regs.sv */
// dual buck control register bank
// assumes straps, gpio and twi pins are asynchronous,
// load current comes from sense logic on i_clk
`timescale 1ns/1ps
`default_nettype none
// Contract
// - task write 1 raises regulator 1 enable
// - task write 1 drops regulator 1 enable
// - task write 1 raises regulator 2 enable
// - task write 1 drops regulator 2 enable
// - task write 1 forces PWM on regulator 1
// - task write 1 returns regulator 1 auto
// - task write 1 forces PWM on regulator 2
// - task write 1 returns regulator 2 auto
// - regulator 1 normal code resets to 2
// - regulator 1 retention code resets to 2
// - regulator 2 normal code resets to 8
// - regulator 2 retention code resets to 8
// - status reports voltage code in effect
// - auto mode PWM at 90 or more, back at 40 or less
// - select bit picks strap or software code
// - task requests override strap power-on state
// - gpio forced PWM beats register forced PWM
module dbc_regs (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_o,
  output logic o_sda_oe,
  input wire logic [4:0] i_gpio,
  input wire logic [1:0] i_strap_on,
  input wire logic [1:0][4:0] i_strap_code,
  input wire logic [1:0][7:0] i_load_ma,
  output logic [1:0] o_enable,
  output logic [1:0] o_pwm,
  output logic [1:0] o_retention,
  output logic [1:0][4:0] o_vout_code
);
  // ----------------
  // state
  // ----------------
  typedef struct packed {
    logic [1:0] init_cnt; // wait for strap sync
    logic [4:0] gpio1; // sync first stage
    logic [4:0] gpio2;
    logic [11:0] strap1;
    logic [11:0] strap2;
    logic [1:0][4:0] strap_code; // caught strap code
    logic [1:0] en; // software enable request
    logic [1:0] fpwm; // register forced pwm
    logic [1:0] pwm_auto; // auto hysteresis state
    logic [1:0][4:0] norm;
    logic [1:0][4:0] ret;
    logic [1:0][4:0] applied; // normal code in force
    logic [7:0] en_pin;
    logic [7:0] ret_pin;
    logic [7:0] pwm_pin;
    logic [1:0] sw_sel;
    logic [3:0] auto_ctl;
    logic [1:0] out_en;
    logic [1:0] out_pwm;
    logic [1:0] out_ret;
    logic [1:0][4:0] vout;
  } dbc_regs_type;
  dbc_regs_type q, d;
  dbc_bus_if bus ();
  // ----------------
  // two-wire slave
  // ----------------
  dbc_twi_slave u_twi (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_scl(i_scl),
    .i_sda(i_sda),
    .o_sda_o(o_sda_o),
    .o_sda_oe(o_sda_oe),
    .bus(bus)
  );
  // ----------------
  // helpers
  // ----------------
  // gpio select field: 1..5 picks a pin, others unused
  // returns {used, level after inversion}
  function automatic logic [1:0] gpio_pick(
    input logic [2:0] sel,
    input logic inv,
    input logic [4:0] g
  );
    logic [1:0] r;
    r = 2'h0;
    if (sel >= 3'h1 && sel <= 3'h5) begin
      r = {1'b1, g[sel - 3'h1] ^ inv};
    end
    return r;
  endfunction
  // write strobe for one offset
  function automatic logic hit(input logic [7:0] a);
    return bus.wr && bus.addr == a;
  endfunction
  logic [1:0][1:0] en_g, ret_g, pwm_g; // per regulator picks
  logic [1:0] en_eff, pwm_force, pfm_only;
  logic [1:0][1:0] mode;
  logic [1:0] set_en, clr_en, set_pwm, clr_pwm;
  logic [7:0] rdata;
  // ----------------
  // per regulator decode
  // ----------------
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      en_g[i] = gpio_pick(q.en_pin[3*i +: 3], q.en_pin[6+i], q.gpio2);
      ret_g[i] = gpio_pick(q.ret_pin[3*i +: 3], q.ret_pin[6+i], q.gpio2);
      pwm_g[i] = gpio_pick(q.pwm_pin[3*i +: 3], q.pwm_pin[6+i], q.gpio2);
      // gpio enable control when selected, else request
      en_eff[i] = en_g[i][1] ? en_g[i][0] : q.en[i];
      // gpio forced pwm overrides register state
      pwm_force[i] = pwm_g[i][1] ? pwm_g[i][0] : q.fpwm[i];
      pfm_only[i] = q.auto_ctl[i];
      if (pwm_force[i]) begin
        mode[i] = dbc_pkg::MODE_PWM;
      end else if (pfm_only[i]) begin
        mode[i] = dbc_pkg::MODE_PFM;
      end else begin
        mode[i] = dbc_pkg::MODE_AUTO;
      end
    end
  end
  // ----------------
  // task strobes
  // ----------------
  // only bit 0 of the written byte triggers, nothing is stored
  always_comb begin
    set_en[0] = hit(dbc_pkg::ADR_EN1_SET) & bus.wdata[0];
    clr_en[0] = hit(dbc_pkg::ADR_EN1_CLR) & bus.wdata[0];
    set_en[1] = hit(dbc_pkg::ADR_EN2_SET) & bus.wdata[0];
    clr_en[1] = hit(dbc_pkg::ADR_EN2_CLR) & bus.wdata[0];
    set_pwm[0] = hit(dbc_pkg::ADR_PWM1_SET) & bus.wdata[0];
    clr_pwm[0] = hit(dbc_pkg::ADR_PWM1_CLR) & bus.wdata[0];
    set_pwm[1] = hit(dbc_pkg::ADR_PWM2_SET) & bus.wdata[0];
    clr_pwm[1] = hit(dbc_pkg::ADR_PWM2_CLR) & bus.wdata[0];
  end
  // ----------------
  // read mux
  // ----------------
  always_comb begin
    rdata = 8'h00;
    unique case (bus.addr)
      dbc_pkg::ADR_NORM1: rdata = {3'h0, q.norm[0]};
      dbc_pkg::ADR_RET1: rdata = {3'h0, q.ret[0]};
      dbc_pkg::ADR_NORM2: rdata = {3'h0, q.norm[1]};
      dbc_pkg::ADR_RET2: rdata = {3'h0, q.ret[1]};
      dbc_pkg::ADR_EN_PIN: rdata = q.en_pin;
      dbc_pkg::ADR_RET_PIN: rdata = q.ret_pin;
      dbc_pkg::ADR_PWM_PIN: rdata = q.pwm_pin;
      dbc_pkg::ADR_SW_SEL: rdata = {6'h00, q.sw_sel};
      // status shows what the outputs carry
      dbc_pkg::ADR_VSTAT1: rdata = {3'h0, q.vout[0]};
      dbc_pkg::ADR_VSTAT2: rdata = {3'h0, q.vout[1]};
      dbc_pkg::ADR_AUTO_CTL: rdata = {4'h0, q.auto_ctl};
      dbc_pkg::ADR_REG_STAT: begin
        rdata = {q.out_pwm[1], q.out_en[1], mode[1],
                 q.out_pwm[0], q.out_en[0], mode[0]};
      end
      // task offsets and holes read zero
      default: rdata = 8'h00;
    endcase
  end
  assign bus.rdata = rdata;
  // ----------------
  // next state
  // ----------------
  always_comb begin
    d = q;
    d.gpio1 = i_gpio;
    d.gpio2 = q.gpio1;
    d.strap1 = {i_strap_on, i_strap_code};
    d.strap2 = q.strap1;
    // catch straps once they have crossed the sync
    if (q.init_cnt != dbc_pkg::STRAP_WAIT) begin
      d.init_cnt = q.init_cnt + 2'h1;
    end
    for (int i = 0; i < 2; i++) begin
      if (q.init_cnt == dbc_pkg::STRAP_WAIT - 2'h1) begin
        d.en[i] = q.strap2[10+i];
        d.strap_code[i] = q.strap2[5*i +: 5];
      end
      // a task after the catch overrides the strap
      if (set_en[i]) begin
        d.en[i] = 1'b1;
      end
      if (clr_en[i]) begin
        d.en[i] = 1'b0;
      end
      if (set_pwm[i]) begin
        d.fpwm[i] = 1'b1;
      end
      if (clr_pwm[i]) begin
        d.fpwm[i] = 1'b0;
      end
      // hysteresis: up at 90 mA, down at 40 mA
      if (i_load_ma[i] >= dbc_pkg::PWM_UP_MA) begin
        d.pwm_auto[i] = 1'b1;
      end else if (i_load_ma[i] <= dbc_pkg::HYST_DN_MA) begin
        d.pwm_auto[i] = 1'b0;
      end
      // registered outputs
      d.out_en[i] = en_eff[i];
      d.out_pwm[i] = en_eff[i] & (pwm_force[i] |
                     (~pfm_only[i] & q.pwm_auto[i]));
      d.out_ret[i] = ret_g[i][1] & ret_g[i][0];
      // retention code wins while its gpio is asserted
      if (ret_g[i][1] && ret_g[i][0]) begin
        d.vout[i] = q.ret[i];
      end else if (q.sw_sel[i]) begin
        d.vout[i] = q.applied[i];
      end else begin
        d.vout[i] = q.strap_code[i];
      end
    end
    // plain register writes
    if (hit(dbc_pkg::ADR_NORM1)) begin
      d.norm[0] = bus.wdata[4:0];
    end
    if (hit(dbc_pkg::ADR_RET1)) begin
      d.ret[0] = bus.wdata[4:0];
    end
    if (hit(dbc_pkg::ADR_NORM2)) begin
      d.norm[1] = bus.wdata[4:0];
    end
    if (hit(dbc_pkg::ADR_RET2)) begin
      d.ret[1] = bus.wdata[4:0];
    end
    if (hit(dbc_pkg::ADR_EN_PIN)) begin
      d.en_pin = bus.wdata;
    end
    if (hit(dbc_pkg::ADR_RET_PIN)) begin
      d.ret_pin = bus.wdata;
    end
    if (hit(dbc_pkg::ADR_PWM_PIN)) begin
      d.pwm_pin = bus.wdata;
    end
    if (hit(dbc_pkg::ADR_AUTO_CTL)) begin
      d.auto_ctl = bus.wdata[3:0];
    end
    // a new normal code waits for this write
    if (hit(dbc_pkg::ADR_SW_SEL)) begin
      d.sw_sel = bus.wdata[1:0];
      d.applied = q.norm;
    end
  end
  // ----------------
  // registers
  // ----------------
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      q <= '0;
      q.norm[0] <= dbc_pkg::RST_CODE1;
      q.ret[0] <= dbc_pkg::RST_CODE1;
      q.norm[1] <= dbc_pkg::RST_CODE2;
      q.ret[1] <= dbc_pkg::RST_CODE2;
      q.applied[0] <= dbc_pkg::RST_CODE1;
      q.applied[1] <= dbc_pkg::RST_CODE2;
    end else begin
      q <= d;
    end
  end
  assign o_enable = q.out_en;
  assign o_pwm = q.out_pwm;
  assign o_retention = q.out_ret;
  assign o_vout_code = q.vout;
  // ----------------
  // checks
  // ----------------
  chk_en1_set: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    set_en[0] |=> q.en[0])
    else $error("enable 1 task lost");
  chk_en1_zero: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    hit(dbc_pkg::ADR_EN1_SET) && !bus.wdata[0] && q.init_cnt == 2'h3
    |=> q.en[0] == $past(q.en[0]))
    else $error("zero write changed enable 1");
  chk_en1_clr: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    clr_en[0] |=> !q.en[0] ##1 (en_g[0][1] || !o_enable[0]))
    else $error("disable 1 task lost");
  chk_en2_pair: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    set_en[1] |=> q.en[1] ##0 $rose(q.en[1]) || $past(q.en[1]))
    else $error("enable 2 task lost");
  chk_en2_clr: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    clr_en[1] |=> !q.en[1])
    else $error("disable 2 task lost");
  chk_pwm1_set: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    set_pwm[0] && !pwm_g[0][1] |=> ##1 mode[0] == dbc_pkg::MODE_PWM)
    else $error("forced pwm 1 not entered");
  chk_pwm1_clr: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    clr_pwm[0] |=> !q.fpwm[0])
    else $error("forced pwm 1 not left");
  chk_pwm2_set: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    set_pwm[1] |=> q.fpwm[1])
    else $error("forced pwm 2 not entered");
  chk_pwm2_clr: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    clr_pwm[1] |=> !q.fpwm[1])
    else $error("forced pwm 2 not left");
  chk_auto_up: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_load_ma[0] >= 8'h5A && en_eff[0] && !pfm_only[0]
    ##1 en_eff[0] |=> o_pwm[0])
    else $error("auto pwm not entered");
  chk_gpio_wins: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    pwm_g[1][1] && !pwm_g[1][0] && q.fpwm[1] && en_eff[1] && pfm_only[1]
    |=> !o_pwm[1])
    else $error("gpio pwm override ignored");
  chk_task_zero: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    bus.addr < dbc_pkg::ADR_NORM1 |-> rdata == 8'h00)
    else $error("task register read nonzero");
  chk_sw_code: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    q.sw_sel[0] && !ret_g[0][1] && $stable(q.applied[0])
    |=> o_vout_code[0] == $past(q.applied[0]))
    else $error("status not the code in force");
  // second regulator follows its applied code as well
  chk_sw2_code: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    q.sw_sel[1] && !ret_g[1][1] |=> o_vout_code[1] == $past(q.applied[1]))
    else $error("code 2 not the applied one");
  // an active retention pin puts the retention code in force
  chk_ret_code: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    ret_g[0][1] && ret_g[0][0] |=> o_vout_code[0] == $past(q.ret[0]))
    else $error("retention code not in force");
  // regulator 1 never reports pwm while it is off
  chk_pwm_off: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !en_eff[0] |=> !o_pwm[0])
    else $error("pwm while regulator 1 off");
  // light load drops auto pwm two cycles later
  chk_auto_down: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_load_ma[0] <= dbc_pkg::HYST_DN_MA && !pwm_force[0] ##1 !pwm_force[0]
    |=> !o_pwm[0])
    else $error("auto pwm not left");
  // the strap level is taken once the sync has settled
  chk_strap_catch: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    q.init_cnt == 2'h2 && !set_en[0] && !clr_en[0] |=> q.en[0] == $past(q.strap2[10]))
    else $error("strap enable not caught");
  chk_en2_off: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    clr_en[1] |=> ##1 (en_g[1][1] || !o_enable[1]))
    else $error("regulator 2 still on after disable");
endmodule
`default_nettype wire

/* File: dbc_pkg.sv */
// constants and types for the dual buck control register bank
// assumes byte-wide registers reached through the two-wire port
package dbc_pkg;
  // register offsets
  localparam logic [7:0] ADR_EN1_SET = 8'h00;
  localparam logic [7:0] ADR_EN1_CLR = 8'h01;
  localparam logic [7:0] ADR_EN2_SET = 8'h02;
  localparam logic [7:0] ADR_EN2_CLR = 8'h03;
  localparam logic [7:0] ADR_PWM1_SET = 8'h04;
  localparam logic [7:0] ADR_PWM1_CLR = 8'h05;
  localparam logic [7:0] ADR_PWM2_SET = 8'h06;
  localparam logic [7:0] ADR_PWM2_CLR = 8'h07;
  localparam logic [7:0] ADR_NORM1 = 8'h08;
  localparam logic [7:0] ADR_RET1 = 8'h09;
  localparam logic [7:0] ADR_NORM2 = 8'h0A;
  localparam logic [7:0] ADR_RET2 = 8'h0B;
  localparam logic [7:0] ADR_EN_PIN = 8'h0C;
  localparam logic [7:0] ADR_RET_PIN = 8'h0D;
  localparam logic [7:0] ADR_PWM_PIN = 8'h0E;
  localparam logic [7:0] ADR_SW_SEL = 8'h0F;
  localparam logic [7:0] ADR_VSTAT1 = 8'h10;
  localparam logic [7:0] ADR_VSTAT2 = 8'h11;
  localparam logic [7:0] ADR_AUTO_CTL = 8'h15;
  localparam logic [7:0] ADR_REG_STAT = 8'h34;
  // reset values of the voltage codes
  localparam logic [4:0] RST_CODE1 = 5'h02;
  localparam logic [4:0] RST_CODE2 = 5'h08;
  // auto mode load thresholds in mA
  localparam logic [7:0] PWM_UP_MA = 8'h5A;
  localparam logic [7:0] HYST_DN_MA = 8'h28;
  // reported mode codes
  localparam logic [1:0] MODE_AUTO = 2'h0;
  localparam logic [1:0] MODE_PFM = 2'h1;
  localparam logic [1:0] MODE_PWM = 2'h2;
  // cycles after reset release before straps are caught
  localparam logic [1:0] STRAP_WAIT = 2'h3;
  // bits per two-wire byte
  localparam logic [3:0] BYTE_BITS = 4'h8;
  // two-wire slave address, value is arbitrary
  localparam logic [6:0] DEV_ADDR = 7'h2B;
  // two-wire slave states
  typedef enum logic [2:0] {
    TW_IDLE = 3'b000,
    TW_ADDR = 3'b001,
    TW_ACK = 3'b010,
    TW_RX = 3'b011,
    TW_TX = 3'b100,
    TW_TXACK = 3'b101
  } dbc_tw_state_type;
endpackage

/* File: dbc_bus_if.sv */
// byte register access between two-wire slave and register bank
// assumes both ends run on the same clock
`timescale 1ns/1ps
`default_nettype none
interface dbc_bus_if;
  logic wr; // one-cycle write strobe
  logic [7:0] addr; // register pointer
  logic [7:0] wdata; // write byte
  logic [7:0] rdata; // read byte for addr
  modport slave (output wr, output addr, output wdata, input rdata);
  modport regs (input wr, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

/* File: dbc_twi_slave.sv */
// two-wire slave with auto-incrementing register pointer
// assumes scl and sda come from pins, open-drain sda
`timescale 1ns/1ps
`default_nettype none
module dbc_twi_slave (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_o,
  output logic o_sda_oe,
  dbc_bus_if.slave bus
);
  // ----------------
  // state
  // ----------------
  typedef struct packed {
    logic [2:0] scl; // sync chain, [0] first
    logic [2:0] sda;
    dbc_pkg::dbc_tw_state_type st;
    logic [3:0] cnt; // bits seen or sent
    logic [7:0] sh; // shift register
    logic rw; // 1 = master reads
    logic have_ptr; // pointer byte received
    logic [7:0] ptr;
    logic oe; // pulling sda low
    logic wr;
    logic [7:0] wdata;
  } dbc_tw_type;
  dbc_tw_type q, d;
  logic rise, fall, start, stop;
  // edges only look at the settled stages
  assign rise = q.scl[1] & ~q.scl[2];
  assign fall = ~q.scl[1] & q.scl[2];
  assign start = q.scl[1] & q.scl[2] & ~q.sda[1] & q.sda[2];
  assign stop = q.scl[1] & q.scl[2] & q.sda[1] & ~q.sda[2];
  // ----------------
  // next state
  // ----------------
  always_comb begin
    d = q;
    d.scl = {q.scl[1:0], i_scl};
    d.sda = {q.sda[1:0], i_sda};
    d.wr = 1'b0;
    // pointer moves once the write is seen
    if (q.wr) begin
      d.ptr = q.ptr + 8'h01;
    end
    if (start) begin
      d.st = dbc_pkg::TW_ADDR;
      d.cnt = 4'h0;
      d.oe = 1'b0;
      d.have_ptr = 1'b0;
    end else if (stop) begin
      d.st = dbc_pkg::TW_IDLE;
      d.oe = 1'b0;
    end else begin
      unique case (q.st)
        dbc_pkg::TW_IDLE: begin
        end
        dbc_pkg::TW_ADDR, dbc_pkg::TW_RX: begin
          if (rise) begin
            d.sh = {q.sh[6:0], q.sda[1]};
            d.cnt = q.cnt + 4'h1;
          end else if (fall && q.cnt == dbc_pkg::BYTE_BITS) begin
            d.cnt = 4'h0;
            d.oe = 1'b1;
            d.st = dbc_pkg::TW_ACK;
            if (q.st == dbc_pkg::TW_ADDR) begin
              d.rw = q.sh[0];
              // foreign address: stay off the bus
              if (q.sh[7:1] != dbc_pkg::DEV_ADDR) begin
                d.oe = 1'b0;
                d.st = dbc_pkg::TW_IDLE;
              end
            end else if (!q.have_ptr) begin
              d.ptr = q.sh;
              d.have_ptr = 1'b1;
            end else begin
              d.wr = 1'b1;
              d.wdata = q.sh;
            end
          end
        end
        dbc_pkg::TW_ACK: begin
          if (fall) begin
            if (q.rw) begin
              // fetch byte and present its msb
              d.sh = bus.rdata;
              d.oe = ~bus.rdata[7];
              d.cnt = 4'h1;
              d.ptr = q.ptr + 8'h01;
              d.st = dbc_pkg::TW_TX;
            end else begin
              d.oe = 1'b0;
              d.st = dbc_pkg::TW_RX;
            end
          end
        end
        dbc_pkg::TW_TX: begin
          if (fall) begin
            if (q.cnt == dbc_pkg::BYTE_BITS) begin
              d.oe = 1'b0;
              d.st = dbc_pkg::TW_TXACK;
            end else begin
              d.sh = {q.sh[6:0], 1'b0};
              d.oe = ~q.sh[6];
              d.cnt = q.cnt + 4'h1;
            end
          end
        end
        dbc_pkg::TW_TXACK: begin
          // master nack ends the read
          if (rise) begin
            d.st = q.sda[1] ? dbc_pkg::TW_IDLE : dbc_pkg::TW_ACK;
          end
        end
        default: begin
          d.st = dbc_pkg::TW_IDLE;
        end
      endcase
    end
  end
  // ----------------
  // registers
  // ----------------
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      q <= '{scl: 3'h7, sda: 3'h7, st: dbc_pkg::TW_IDLE, default: '0};
    end else begin
      q <= d;
    end
  end
  assign o_sda_o = 1'b0;
  assign o_sda_oe = q.oe;
  assign bus.wr = q.wr;
  assign bus.addr = q.ptr;
  assign bus.wdata = q.wdata;
endmodule
`default_nettype wire

/* File: dbc_regs_tb_top.sv */
// self-checking bench for the dual buck control register bank
// assumes the bench alone drives the two-wire pins, straps and load sense
`timescale 1ns/1ps
`default_nettype none
module dbc_regs_tb_top;
  // ----------------------------------------
  // stimulus and observed signals
  // ----------------------------------------
  logic clk = 1'b0; // 100 MHz system clock
  logic rst_n = 1'b0; // async reset, low active
  logic scl = 1'b1; // bench is the only bus master
  logic sda_pull = 1'b0; // bench pulls sda low when set
  logic [4:0] gpio = 5'h0_0; // pin selects start at zero, so unused until t_gpio
  logic [1:0] strap_on = 2'h0; // both regulators strapped off
  logic [1:0][4:0] strap_code = {5'h0_A, 5'h0_3}; // distinct from reset codes
  logic [1:0][7:0] load = 16'h0000; // load sense in mA
  logic sda_o; // device data value, open drain
  logic sda_oe; // device pulls sda low
  logic [1:0] en; // regulator on
  logic [1:0] pwm; // regulator in pwm
  logic [1:0] ret; // retention active
  logic [1:0][4:0] vcode; // code in effect
  wire sda_line; // open-drain wire with pull-up
  int bad_count = 0; // mismatches seen
  int cmp_count = 0; // comparisons made
  logic [7:0] rd; // last byte read back
  // either party pulling wins; otherwise the pull-up holds it high
  assign sda_line = (sda_pull || (sda_oe && !sda_o)) ? 1'b0 : 1'b1;
  dbc_regs u_dut (
    .i_clk(clk), .i_rst_n(rst_n), .i_scl(scl), .i_sda(sda_line),
    .o_sda_o(sda_o), .o_sda_oe(sda_oe), .i_gpio(gpio),
    .i_strap_on(strap_on), .i_strap_code(strap_code), .i_load_ma(load),
    .o_enable(en), .o_pwm(pwm), .o_retention(ret), .o_vout_code(vcode)
  );
  // ----------------------------------------
  // clock, verdict and watchdog
  // ----------------------------------------
  initial begin
    forever #5 clk = ~clk;
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // the whole run needs roughly 19k cycles, so 100k means a hang
  initial begin
    repeat (100000) @(negedge clk);
    bad_count++;
    close_out();
  end
  // ----------------------------------------
  // helpers: cycles, compare, bus bits
  // ----------------------------------------
  task automatic hclk(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      $display("Error t=%0t got %h exp %h", $time, got, exp);
      bad_count++;
    end
  endtask
  // sda only moves two cycles after scl fell, so the synchroniser
  // never sees both change in one cycle and mistakes it for a start
  task automatic tw_bit(input logic b, output logic r);
    hclk(2);
    sda_pull = ~b;
    hclk(6);
    scl = 1'b1;
    hclk(4);
    r = sda_line;
    hclk(4);
    scl = 1'b0;
  endtask
  // start, also used as repeated start
  task automatic tw_start();
    hclk(2);
    sda_pull = 1'b0;
    hclk(4);
    scl = 1'b1;
    hclk(4);
    sda_pull = 1'b1;
    hclk(4);
    scl = 1'b0;
  endtask
  task automatic tw_stop();
    hclk(2);
    sda_pull = 1'b1;
    hclk(4);
    scl = 1'b1;
    hclk(4);
    sda_pull = 1'b0;
    hclk(8);
  endtask
  // byte out msb first, then the device must acknowledge
  task automatic tw_put(input logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      tw_bit(b[i], r);
    end
    tw_bit(1'b1, r);
    chk({7'h0_0, r}, 8'h0_0);
  endtask
  // byte in, closed by a master nack
  task automatic tw_get(output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      tw_bit(1'b1, b[i]);
    end
    tw_bit(1'b1, r);
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    tw_start();
    tw_put({dbc_pkg::DEV_ADDR, 1'b0});
    tw_put(a);
    tw_put(d);
    tw_stop();
    hclk(4);
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    tw_start();
    tw_put({dbc_pkg::DEV_ADDR, 1'b0});
    tw_put(a);
    tw_start();
    tw_put({dbc_pkg::DEV_ADDR, 1'b1});
    tw_get(d);
    tw_stop();
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  // reset codes, unmapped read and strapped-off enables
  task automatic t_reset();
    rd_reg(dbc_pkg::ADR_NORM1, rd);
    chk(rd, 8'h0_2);
    rd_reg(dbc_pkg::ADR_RET1, rd);
    chk(rd, 8'h0_2);
    rd_reg(dbc_pkg::ADR_NORM2, rd);
    chk(rd, 8'h0_8);
    rd_reg(dbc_pkg::ADR_RET2, rd);
    chk(rd, 8'h0_8);
    rd_reg(8'h2_0, rd);
    chk(rd, 8'h0_0); // unmapped place reads zero
    chk({6'h0_0, en}, 8'h0_0); // straps said off
    $display("test reset values done");
  endtask
  // enable and disable tasks, zero writes first
  task automatic t_enable();
    wr_reg(dbc_pkg::ADR_EN1_SET, 8'h0_0);
    chk({6'h0_0, en}, 8'h0_0);
    wr_reg(dbc_pkg::ADR_EN1_SET, 8'h0_1);
    chk({6'h0_0, en}, 8'h0_1);
    wr_reg(dbc_pkg::ADR_EN2_SET, 8'h0_0);
    chk({6'h0_0, en}, 8'h0_1);
    wr_reg(dbc_pkg::ADR_EN2_SET, 8'h0_1);
    chk({6'h0_0, en}, 8'h0_3);
    rd_reg(dbc_pkg::ADR_EN1_SET, rd);
    chk(rd, 8'h0_0);
    wr_reg(dbc_pkg::ADR_EN1_CLR, 8'h0_0);
    chk({6'h0_0, en}, 8'h0_3);
    wr_reg(dbc_pkg::ADR_EN1_CLR, 8'h0_1);
    chk({6'h0_0, en}, 8'h0_2);
    wr_reg(dbc_pkg::ADR_EN2_CLR, 8'h0_0);
    chk({6'h0_0, en}, 8'h0_2);
    wr_reg(dbc_pkg::ADR_EN2_CLR, 8'h0_1);
    chk({6'h0_0, en}, 8'h0_0);
    $display("test enable tasks done");
  endtask
  // forced pwm set and clear on both regulators, load kept low
  task automatic t_pwm();
    wr_reg(dbc_pkg::ADR_EN1_SET, 8'h0_1);
    wr_reg(dbc_pkg::ADR_EN2_SET, 8'h0_1);
    chk({6'h0_0, pwm}, 8'h0_0);
    wr_reg(dbc_pkg::ADR_PWM1_SET, 8'h0_0);
    chk({6'h0_0, pwm}, 8'h0_0);
    wr_reg(dbc_pkg::ADR_PWM1_SET, 8'h0_1);
    chk({6'h0_0, pwm}, 8'h0_1);
    wr_reg(dbc_pkg::ADR_PWM2_SET, 8'h0_1);
    chk({6'h0_0, pwm}, 8'h0_3);
    rd_reg(dbc_pkg::ADR_PWM2_SET, rd);
    chk(rd, 8'h0_0);
    wr_reg(dbc_pkg::ADR_PWM1_CLR, 8'h0_0);
    chk({6'h0_0, pwm}, 8'h0_3);
    wr_reg(dbc_pkg::ADR_PWM1_CLR, 8'h0_1);
    chk({6'h0_0, pwm}, 8'h0_2);
    wr_reg(dbc_pkg::ADR_PWM2_CLR, 8'h0_1);
    chk({6'h0_0, pwm}, 8'h0_0);
    $display("test forced pwm tasks done");
  endtask
  // automatic mode hysteresis on regulator 1, band edges on both sides
  task automatic t_auto();
    load[0] = 8'h5_9;
    hclk(4);
    chk({6'h0_0, pwm}, 8'h0_0);
    load[0] = 8'h5_A;
    hclk(4);
    chk({6'h0_0, pwm}, 8'h0_1);
    load[0] = 8'h2_9;
    hclk(4);
    chk({6'h0_0, pwm}, 8'h0_1);
    load[0] = 8'h2_8;
    hclk(4);
    chk({6'h0_0, pwm}, 8'h0_0);
    $display("test auto mode done");
  endtask
  // new normal code waits for the select write, then shows in status
  task automatic t_vout();
    chk({3'h0, vcode[0]}, 8'h0_3); // strap code in effect
    wr_reg(dbc_pkg::ADR_NORM1, 8'h1_1);
    chk({3'h0, vcode[0]}, 8'h0_3);
    wr_reg(dbc_pkg::ADR_SW_SEL, 8'h0_1);
    chk({3'h0, vcode[0]}, 8'h1_1);
    chk({3'h0, vcode[1]}, 8'h0_A);
    rd_reg(dbc_pkg::ADR_VSTAT1, rd);
    chk(rd, 8'h1_1);
    rd_reg(dbc_pkg::ADR_VSTAT2, rd);
    chk(rd, 8'h0_A);
    wr_reg(dbc_pkg::ADR_NORM1, 8'h0_5);
    chk({3'h0, vcode[0]}, 8'h1_1);
    wr_reg(dbc_pkg::ADR_SW_SEL, 8'h0_3);
    chk({3'h0, vcode[0]}, 8'h0_5);
    chk({3'h0, vcode[1]}, 8'h0_8);
    $display("test voltage select done");
  endtask
  // gpio pins against register state: forced pwm, pfm only, retention code
  task automatic t_gpio();
    wr_reg(dbc_pkg::ADR_PWM2_SET, 8'h0_1);
    wr_reg(dbc_pkg::ADR_AUTO_CTL, 8'h0_2);
    chk({6'h0_0, pwm}, 8'h0_2);
    wr_reg(dbc_pkg::ADR_PWM_PIN, 8'h0_8);
    chk({6'h0_0, pwm}, 8'h0_0);
    rd_reg(dbc_pkg::ADR_REG_STAT, rd);
    chk(rd, 8'h5_4);
    gpio = 5'h0_1;
    hclk(6);
    chk({6'h0_0, pwm}, 8'h0_2);
    wr_reg(dbc_pkg::ADR_RET_PIN, 8'h0_2);
    chk({6'h0_0, ret}, 8'h0_0);
    gpio = 5'h0_3;
    hclk(6);
    chk({6'h0_0, ret}, 8'h0_1);
    rd_reg(dbc_pkg::ADR_VSTAT1, rd);
    chk(rd, 8'h0_2);
    gpio = 5'h0_0;
    hclk(6);
    chk({3'h0, vcode[0]}, 8'h0_5);
    $display("test gpio overrides done");
  endtask
  // second reset with both straps on, then a task overrides one
  task automatic t_strap();
    strap_on = 2'h3;
    rst_n = 1'b0;
    hclk(4);
    rst_n = 1'b1;
    hclk(10);
    chk({6'h0_0, en}, 8'h0_3);
    chk({3'h0, vcode[1]}, 8'h0_A);
    wr_reg(dbc_pkg::ADR_EN2_CLR, 8'h0_1);
    chk({6'h0_0, en}, 8'h0_1);
    $display("test strap override done");
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    hclk(4);
    rst_n = 1'b1;
    hclk(10);
    t_reset();
    t_enable();
    t_pwm();
    t_auto();
    t_vout();
    t_gpio();
    t_strap();
    close_out();
  end
endmodule
`default_nettype wire
